// *** nri_host.sv ***
// host controller: reset, id, signature, alternate id and parameter page reads
// assumes device pins are asynchronous; ready/busy passes a two-flop synchroniser
`timescale 1ns/1ps
module nri_host #(
  parameter int ALT_BYTES = 8
) (
  // clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // user request
  input  wire logic       i_req_valid,
  input  wire logic [2:0] i_req_op,
  output logic            o_req_ready,
  // user read data
  output logic            o_rd_valid,
  output logic [7:0]      o_rd_data,
  input  wire logic       i_rd_ready,
  output logic            o_done,
  output logic            o_init_done,
  // nand pins
  output logic            o_ce_n,
  output logic            o_cle,
  output logic            o_ale,
  output logic            o_we_n,
  output logic            o_read_enable_n,
  output logic [7:0]      o_io,
  output logic            o_io_oe,
  input  wire logic [7:0] i_io,
  input  wire logic       i_rb_n
);

  typedef enum logic [3:0] {
    NRI_IDLE  = 4'b0000,
    NRI_CMD   = 4'b0001,
    NRI_ADDR  = 4'b0011,
    NRI_WB    = 4'b0010,
    NRI_BUSY  = 4'b0110,
    NRI_READ  = 4'b0111,
    NRI_FIN   = 4'b0101,
    NRI_CMD2  = 4'b0100
  } nri_state_e;

  nri_state_e  state;
  logic [2:0]  op;
  logic [3:0]  seq_idx;    // command index within sequence
  logic [7:0]  strobe_cnt;
  logic [7:0]  byte_cnt;
  logic [7:0]  wb_cnt;
  logic        did_init;
  logic        pend_dummy; // last op left device in an id-like mode
  logic        rb_m;
  logic        rb_s;
  logic        phase;      // 0: strobe low, 1: strobe high
  logic        strobe_end;
  logic [7:0]  n_cmd;
  logic [7:0]  n_addr;
  logic [3:0]  n_addr_cnt;
  logic [7:0]  n_reads;
  logic        n_wait_rb;
  // two-entry skid buffer on the read path
  logic [7:0]  buf_data [2];
  logic        buf_wr;
  logic [1:0]  buf_cnt;
  logic        buf_rd_ptr;
  logic        buf_wr_ptr;
  logic        buf_ready;
  logic        buf_pop;

  // ready/busy synchroniser
  always_ff @(posedge i_sys_clk) begin
    rb_m <= i_rb_n;
    rb_s <= rb_m;
  end

  // per-operation sequence tables
  always_comb begin
    n_cmd      = nri_pkg::CMD_RESET;
    n_addr     = nri_pkg::ADDR_ID;
    n_addr_cnt = 4'h0;
    n_reads    = 8'h00;
    n_wait_rb  = 1'b0;
    case (op)
      nri_pkg::NRI_OP_RESET: begin
        n_wait_rb = 1'b1;
      end
      nri_pkg::NRI_OP_ID: begin
        n_cmd      = (seq_idx == 4'h0 && pend_dummy) ? nri_pkg::CMD_READ : nri_pkg::CMD_READ_ID;
        n_addr     = nri_pkg::ADDR_ID;
        n_addr_cnt = 4'h1;
        n_reads    = 8'(nri_pkg::ID_BYTES);
      end
      nri_pkg::NRI_OP_ONFI: begin
        n_cmd      = nri_pkg::CMD_READ_ID;
        n_addr     = nri_pkg::ADDR_ONFI;
        n_addr_cnt = 4'h1;
        n_reads    = 8'(nri_pkg::SIG_BYTES);
      end
      nri_pkg::NRI_OP_PARAM: begin
        n_cmd      = nri_pkg::CMD_PARAM;
        n_addr     = nri_pkg::ADDR_PARAM;
        n_addr_cnt = 4'h1;
        n_reads    = 8'(nri_pkg::PARAM_BYTES);
        n_wait_rb  = 1'b1;
      end
      nri_pkg::NRI_OP_ALT: begin
        case (seq_idx)
          4'h0:    n_cmd = nri_pkg::CMD_ALT_A;
          4'h1:    n_cmd = nri_pkg::CMD_ALT_B;
          4'h2:    n_cmd = nri_pkg::CMD_ALT_C;
          default: n_cmd = nri_pkg::CMD_ALT_CONF;
        endcase
        case (byte_cnt[2:0])
          3'h0:    n_addr = nri_pkg::ALT_ADDR0;
          3'h1:    n_addr = nri_pkg::ALT_ADDR1;
          3'h2:    n_addr = nri_pkg::ALT_ADDR2;
          3'h3:    n_addr = nri_pkg::ALT_ADDR3;
          default: n_addr = nri_pkg::ALT_ADDR4;
        endcase
        n_addr_cnt = 4'(nri_pkg::ALT_ADDR_N);
        n_reads    = 8'(ALT_BYTES);
      end
      default: begin
        // status: dummy 00h first when the device still sits in an id mode
        n_cmd   = (seq_idx == 4'h0 && pend_dummy) ? nri_pkg::CMD_READ : nri_pkg::CMD_STATUS;
        n_reads = 8'h01;
      end
    endcase
  end

  assign strobe_end = (strobe_cnt == 8'(nri_pkg::STROBE_CYC - 1));
  assign o_req_ready = (state == NRI_IDLE) && (did_init || i_req_op == 3'(nri_pkg::NRI_OP_RESET));

  // strobe timing counter, shared by write and read pulses
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || state == NRI_IDLE || state == NRI_WB || state == NRI_BUSY || strobe_end) begin
      strobe_cnt <= 8'h00;
    end else if (state != NRI_READ || buf_ready || phase) begin
      strobe_cnt <= strobe_cnt + 8'h01;
    end
  end

  // main sequencer
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state      <= NRI_IDLE;
      op         <= 3'h0;
      seq_idx    <= 4'h0;
      byte_cnt   <= 8'h00;
      wb_cnt     <= 8'h00;
      phase      <= 1'b0;
      did_init   <= 1'b0;
      pend_dummy <= 1'b0;
    end else begin
      case (state)
        NRI_IDLE: begin
          if (i_req_valid && o_req_ready) begin
            op       <= i_req_op;
            seq_idx  <= 4'h0;
            byte_cnt <= 8'h00;
            phase    <= 1'b0;
            state    <= NRI_CMD;
          end
        end
        NRI_CMD: begin
          if (strobe_end) begin
            phase <= ~phase;
            if (phase) begin
              seq_idx <= seq_idx + 4'h1;
              // only the leading slot is a dummy; the alternate prefix also carries 00h
              if (seq_idx == 4'h0 && pend_dummy && n_cmd == nri_pkg::CMD_READ) begin
                pend_dummy <= 1'b0;
                state      <= NRI_CMD;
              end else if (op == 3'(nri_pkg::NRI_OP_ALT) && seq_idx < 4'h2) begin
                state <= NRI_CMD;
              end else if (n_addr_cnt != 4'h0) begin
                state <= NRI_ADDR;
              end else begin
                wb_cnt <= 8'h00;
                state  <= NRI_WB;
              end
            end
          end
        end
        NRI_ADDR: begin
          if (strobe_end) begin
            phase <= ~phase;
            if (phase) begin
              byte_cnt <= byte_cnt + 8'h01;
              if (byte_cnt + 8'h01 == 8'(n_addr_cnt)) begin
                byte_cnt <= 8'h00;
                wb_cnt   <= 8'h00;
                state    <= (op == 3'(nri_pkg::NRI_OP_ALT)) ? NRI_CMD2 : NRI_WB;
              end
            end
          end
        end
        NRI_CMD2: begin
          // alternate id confirm command
          if (strobe_end) begin
            phase <= ~phase;
            if (phase) begin
              state <= NRI_WB;
            end
          end
        end
        NRI_WB: begin
          // let ready/busy fall before sampling it
          wb_cnt <= wb_cnt + 8'h01;
          if (wb_cnt == 8'(nri_pkg::WB_CYC)) begin
            state <= n_wait_rb ? NRI_BUSY : (n_reads != 8'h00 ? NRI_READ : NRI_FIN);
          end
        end
        NRI_BUSY: begin
          if (rb_s) begin
            state <= (n_reads != 8'h00) ? NRI_READ : NRI_FIN;
            if (op == 3'(nri_pkg::NRI_OP_RESET)) begin
              did_init   <= 1'b1;
              pend_dummy <= 1'b0;
            end
          end
        end
        NRI_READ: begin
          if (strobe_end) begin
            phase <= ~phase;
            if (phase) begin
              byte_cnt <= byte_cnt + 8'h01;
              if (byte_cnt + 8'h01 == n_reads) begin
                state <= NRI_FIN;
              end
            end
          end
        end
        default: begin
          // id-like modes persist, so a later status needs the dummy read command
          pend_dummy <= (op != 3'(nri_pkg::NRI_OP_STATUS) && op != 3'(nri_pkg::NRI_OP_RESET));
          state      <= NRI_IDLE;
        end
      endcase
    end
  end

  // read byte capture at the end of the low read strobe, one cycle before it rises
  assign buf_wr = (state == NRI_READ) && strobe_end && !phase;

  // pins: strobes low in phase 0, data driven on writes
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_ce_n          <= 1'b1;
      o_cle           <= 1'b0;
      o_ale           <= 1'b0;
      o_we_n          <= 1'b1;
      o_read_enable_n <= 1'b1;
      o_io            <= 8'h00;
      o_io_oe         <= 1'b0;
    end else begin
      o_ce_n          <= (state == NRI_IDLE);
      o_cle           <= (state == NRI_CMD || state == NRI_CMD2);
      o_ale           <= (state == NRI_ADDR);
      o_we_n          <= !((state == NRI_CMD || state == NRI_CMD2 || state == NRI_ADDR) && !phase);
      o_read_enable_n <= !((state == NRI_READ) && !phase && (buf_ready || strobe_cnt != 8'h00));
      o_io            <= (state == NRI_ADDR) ? n_addr :
                         (state == NRI_CMD2) ? nri_pkg::CMD_ALT_CONF : n_cmd;
      o_io_oe         <= (state == NRI_CMD || state == NRI_CMD2 || state == NRI_ADDR);
    end
  end

  // buffer: a new read strobe starts only when an entry is free
  assign buf_ready = (buf_cnt != 2'd2);
  assign buf_pop   = o_rd_valid && i_rd_ready;
  assign o_rd_valid = (buf_cnt != 2'd0);
  assign o_rd_data  = buf_data[buf_rd_ptr];

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      buf_cnt    <= 2'd0;
      buf_rd_ptr <= 1'b0;
      buf_wr_ptr <= 1'b0;
    end else begin
      buf_cnt <= buf_cnt + 2'(buf_wr) - 2'(buf_pop);
      if (buf_wr) begin
        buf_wr_ptr <= ~buf_wr_ptr;
      end
      if (buf_pop) begin
        buf_rd_ptr <= ~buf_rd_ptr;
      end
    end
  end

  // buffer storage, pins sampled twice before use
  logic [7:0] io_m;
  logic [7:0] io_s;
  always_ff @(posedge i_sys_clk) begin
    io_m <= i_io;
    io_s <= io_m;
    if (buf_wr) begin
      buf_data[buf_wr_ptr] <= io_s;
    end
  end

  // completion pulse and init flag
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_done      <= 1'b0;
      o_init_done <= 1'b0;
    end else begin
      o_done      <= (state == NRI_FIN);
      o_init_done <= did_init;
    end
  end

endmodule

// *** nri_host_chk.sv ***
// checker for the nand host pin sequencing, sees only nri_host ports
// assumes bind to every nri_host instance; one clock, sync reset
`timescale 1ns/1ps
module nri_host_chk #(
  parameter int ALT_BYTES = 8
) (
  // clock and reset
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  // user side
  input wire logic       i_req_valid,
  input wire logic [2:0] i_req_op,
  input wire logic       o_req_ready,
  input wire logic       o_rd_valid,
  input wire logic [7:0] o_rd_data,
  input wire logic       i_rd_ready,
  input wire logic       o_done,
  input wire logic       o_init_done,
  // nand pins
  input wire logic       o_ce_n,
  input wire logic       o_cle,
  input wire logic       o_ale,
  input wire logic       o_we_n,
  input wire logic       o_read_enable_n,
  input wire logic [7:0] o_io,
  input wire logic       o_io_oe,
  input wire logic [7:0] i_io,
  input wire logic       i_rb_n
);
  logic [7:0] last_cmd;

  // previous command byte, so a new command can be judged against it
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      last_cmd <= 8'h00_FF;
    end else if ($rose(o_we_n) && $past(o_cle)) begin
      last_cmd <= $past(o_io);
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_reset_first: assert property (!o_init_done && !o_we_n && o_cle |-> o_io == 8'h00_FF)
    else $error("command other than reset before init");
  a_refuse_early: assert property (!o_init_done && i_req_op != nri_pkg::NRI_OP_RESET |-> !o_req_ready)
    else $error("request accepted before init");
  a_we_width: assert property ($fell(o_we_n) |-> (!o_we_n)[*5] ##1 o_we_n)
    else $error("write strobe width wrong");
  a_re_width: assert property ($fell(o_read_enable_n) |-> (!o_read_enable_n)[*5] ##1 o_read_enable_n)
    else $error("read strobe width wrong");
  a_strobe_owner: assert property (!o_we_n || !o_read_enable_n |-> !o_ce_n && (o_io_oe == !o_we_n))
    else $error("strobe without select or bus owner wrong");
  a_read_ready: assert property ($fell(o_read_enable_n) |-> i_rb_n && $past(i_rb_n, 2))
    else $error("read strobe while device busy");
  a_status_dummy: assert property (!o_we_n && o_cle && o_io == 8'h00_70
    |-> !(last_cmd inside {8'h00_90, 8'h00_EC, 8'h00_30}))
    else $error("status without dummy command");
  a_alt_order: assert property (!o_we_n && o_cle && o_io == 8'h00_65 |-> last_cmd == 8'h00_30)
    else $error("alternate id prefix out of order");
  a_param_addr: assert property (!o_we_n && o_ale && last_cmd == 8'h00_EC |-> o_io == 8'h00_00)
    else $error("parameter page address wrong");
  a_init_ready: assert property ($rose(o_init_done) |-> i_rb_n)
    else $error("init done while device busy");
endmodule

bind nri_host nri_host_chk #(.ALT_BYTES(ALT_BYTES)) nri_host_chk_i (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req_op(i_req_op),
  .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .i_rd_ready(i_rd_ready),
  .o_done(o_done), .o_init_done(o_init_done), .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale),
  .o_we_n(o_we_n), .o_read_enable_n(o_read_enable_n), .o_io(o_io), .o_io_oe(o_io_oe),
  .i_io(i_io), .i_rb_n(i_rb_n));

// *** nri_nand_model.sv ***
// behavioural nand device: reset, id, signature, alternate id, parameter page, status
// assumes host strobes are glitch free; clock used only to time busy
`timescale 1ns/1ps
module nri_nand_model #(
  parameter logic [7:0] MAKER_CODE  = 8'h00_A5, // arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h00_5A, // arbitrary value
  parameter int         BUSY_CYC    = 40
) (
  // busy timing clock and write-protect level
  input  wire logic       i_clk,
  input  wire logic       i_wp,
  // host strobes and resolved bus
  input  wire logic       i_ce_n,
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_we_n,
  input  wire logic       i_read_enable_n,
  input  wire logic [7:0] i_bus,
  // device outputs and count of host protocol faults
  output logic [7:0]      o_io,
  output logic            o_rb_n,
  output int              o_bad
);
  logic [7:0] status = 8'h00_E0;
  logic [7:0] held   = 8'h00_00;
  logic [7:0] cur;
  logic [7:0] pp [6] = '{8'h00_4F, 8'h00_4E, 8'h00_46, 8'h00_49, 8'h00_02, 8'h00_00};
  int         mode   = 0;
  int         idx    = 0;
  int         busy   = 0;
  int         alt    = 0;
  bit         rst_busy = 0;

  initial o_bad = 0;

  // command and address latch; mode changes on a command or on the address after 90h / ECh
  always @(posedge i_we_n) begin
    if (!i_ce_n && i_cle && !(rst_busy && i_bus == 8'h00_FF)) begin
      idx = 0;
      case (i_bus)
        8'h00_FF: begin
          mode = 0;
          status = i_wp ? 8'h00_E0 : 8'h00_60;
          busy = BUSY_CYC;
          rst_busy = 1;
        end
        8'h00_90: mode = 6;
        8'h00_EC: mode = 7;
        8'h00_70: begin
          if (mode inside {[1:4]}) o_bad++;
          mode = 5;
        end
        8'h00_30: mode = (alt == 8) ? 4 : 0;
        default: mode = 0;
      endcase
      // alternate id prefix tracking: 30h, 65h, 00h, then addresses
      if (i_bus == 8'h00_30 && alt != 8) alt = 1;
      else if (i_bus == 8'h00_65 && alt == 1) alt = 2;
      else if (i_bus == 8'h00_00 && alt == 2) alt = 3;
      else alt = 0;
    end else if (!i_ce_n && i_ale) begin
      idx = 0;
      if (mode == 6) mode = (i_bus == 8'h00_20) ? 2 : (i_bus == 8'h00_00) ? 1 : 0;
      else if (mode == 7 && i_bus == 8'h00_00) begin
        mode = 3;
        busy = BUSY_CYC;
      end else if (alt >= 3 && alt < 8) begin
        if (i_bus !== ((alt == 4 || alt == 5) ? 8'h00_02 : 8'h00_00)) o_bad++;
        alt++;
      end
    end
  end

  // busy countdown; reset command accepted again once ready
  always @(posedge i_clk) begin
    if (busy > 0) busy--;
    if (busy == 0) rst_busy = 0;
  end
  assign o_rb_n = (busy == 0);

  // each read strobe moves to the next byte; reading while busy is a host fault
  always @(posedge i_read_enable_n) begin
    if (!i_ce_n) begin
      if (busy > 0) o_bad++;
      held = cur;
      idx++;
    end
  end

  // byte for the current mode and position
  always_comb begin
    case (mode)
      1: cur = (idx == 0) ? MAKER_CODE : (idx == 1) ? DEVICE_CODE : (idx == 3) ? 8'h00_1A : 8'h00_00;
      2: cur = (idx < 4) ? pp[idx] : ~held;
      3: cur = (idx < 6) ? pp[idx] : ~held;
      4: cur = 8'h00_FF;
      5: cur = status;
      default: cur = ~held;
    endcase
  end
  // released bus shows a changing value, never the last byte
  assign o_io = (!i_ce_n && !i_read_enable_n) ? cur : ~held;
endmodule

// *** nri_pkg.sv ***
// package for the nand reset / identification host controller
// assumes an asynchronous 8-bit multiplexed nand bus driven by one system clock
package nri_pkg;
  // command codes
  localparam logic [7:0] CMD_RESET     = 8'h00_FF;
  localparam logic [7:0] CMD_READ_ID   = 8'h00_90;
  localparam logic [7:0] CMD_READ      = 8'h00_00;
  localparam logic [7:0] CMD_STATUS    = 8'h00_70;
  localparam logic [7:0] CMD_PARAM     = 8'h00_EC;
  localparam logic [7:0] CMD_ALT_A     = 8'h00_30;
  localparam logic [7:0] CMD_ALT_B     = 8'h00_65;
  localparam logic [7:0] CMD_ALT_C     = 8'h00_00;
  localparam logic [7:0] CMD_ALT_CONF  = 8'h00_30;
  // address bytes
  localparam logic [7:0] ADDR_ID       = 8'h00_00;
  localparam logic [7:0] ADDR_ONFI     = 8'h00_20;
  localparam logic [7:0] ADDR_PARAM    = 8'h00_00;
  localparam logic [7:0] ALT_ADDR0     = 8'h00_00;
  localparam logic [7:0] ALT_ADDR1     = 8'h00_02;
  localparam logic [7:0] ALT_ADDR2     = 8'h00_02;
  localparam logic [7:0] ALT_ADDR3     = 8'h00_00;
  localparam logic [7:0] ALT_ADDR4     = 8'h00_00;
  localparam int         ALT_ADDR_N    = 5;
  // read counts per operation
  localparam int         ID_BYTES      = 5;
  localparam int         SIG_BYTES     = 4;
  localparam int         PARAM_BYTES   = 6;
  // status values after reset
  localparam logic [7:0] STAT_RST_WP_HI = 8'h00_E0;
  localparam logic [7:0] STAT_RST_WP_LO = 8'h00_60;
  localparam int         STAT_WP_BIT    = 7;
  // bus timing, ns and derived cycles at 250 mhz
  localparam int         CLK_PERIOD_NS = 4;
  localparam int         T_STROBE_NS   = 20;
  localparam int         STROBE_CYC    = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         T_WB_NS       = 100;
  localparam int         WB_CYC        = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // operations requested by the user
  typedef enum logic [2:0] {
    NRI_OP_RESET  = 3'h0,
    NRI_OP_ID     = 3'h1,
    NRI_OP_ONFI   = 3'h2,
    NRI_OP_PARAM  = 3'h3,
    NRI_OP_ALT    = 3'h4,
    NRI_OP_STATUS = 3'h5
  } nri_op_e;
endpackage

// *** tb_nri_host.sv ***
// self-checking bench for nri_host against the behavioural nand model
// assumes nri_pkg, nri_host, nri_nand_model and the bound checker are compiled
`timescale 1ns/1ps
module tb_nri_host;
  localparam logic [7:0] MAKER  = 8'h00_A5; // arbitrary value
  localparam logic [7:0] DEVICE = 8'h00_5A; // arbitrary value
  logic       i_sys_clk = 0;
  logic       i_rst = 1, i_req_valid = 0, i_rd_ready = 0, wp = 1;
  logic [2:0] i_req_op = 3'h0;
  logic       o_req_ready, o_rd_valid, o_done, o_init_done, o_ce_n, o_cle, o_ale, o_we_n;
  logic       o_read_enable_n, o_io_oe, rb_n;
  logic [7:0] o_rd_data, o_io, dev_io, bus;
  logic [7:0] got [$];
  int         bad, error_cnt = 0, checked = 0;

  // resolved bus: host owns it only while its enable is high
  assign bus = o_io_oe ? o_io : dev_io;

  nri_host #(.ALT_BYTES(8)) nri_host_i (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req_op(i_req_op),
    .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .i_rd_ready(i_rd_ready),
    .o_done(o_done), .o_init_done(o_init_done), .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale),
    .o_we_n(o_we_n), .o_read_enable_n(o_read_enable_n), .o_io(o_io), .o_io_oe(o_io_oe),
    .i_io(bus), .i_rb_n(rb_n));
  nri_nand_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE), .BUSY_CYC(40)) nri_nand_model_i (
    .i_clk(i_sys_clk), .i_wp(wp), .i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n),
    .i_read_enable_n(o_read_enable_n), .i_bus(bus), .o_io(dev_io), .o_rb_n(rb_n), .o_bad(bad));

  // 250 mhz clock
  always #2 i_sys_clk = ~i_sys_clk;

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_flag(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // request one op, collect bytes with an optional consumer stall, wait for done
  task automatic run_op(input logic [2:0] op, input int n, input int stall);
    int k;
    bit done;
    got.delete();
    done = 0;
    k = 0;
    @(negedge i_sys_clk);
    i_req_valid = 1;
    i_req_op = op;
    while (o_req_ready !== 1'b1 && k < 5000) begin
      @(negedge i_sys_clk);
      k++;
    end
    k = (k >= 5000) ? 20000 : 0;
    while ((!done || got.size() < n) && k < 20000) begin
      @(negedge i_sys_clk);
      k++;
      i_req_valid = 0;
      i_rd_ready = (k > stall);
      if (o_rd_valid === 1'b1 && i_rd_ready) got.push_back(o_rd_data);
      if (o_done === 1'b1) done = 1;
    end
    if (k >= 20000) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  task automatic chk_seq(input logic [7:0] e [$]);
    foreach (e[i]) chk_byte(got[i], e[i]);
  endtask

  task automatic t_refused();
    @(negedge i_sys_clk);
    i_req_valid = 1;
    i_req_op = nri_pkg::NRI_OP_ID;
    @(negedge i_sys_clk);
    chk_flag(o_req_ready, 1'b0);
    i_req_valid = 0;
  endtask

  task automatic t_reset(input logic w, input logic [7:0] st);
    wp = w;
    run_op(nri_pkg::NRI_OP_RESET, 0, 0);
    chk_flag(o_init_done, 1'b1);
    run_op(nri_pkg::NRI_OP_STATUS, 1, 0);
    chk_seq('{st});
  endtask

  // id read with the consumer stalled long enough to fill the buffer
  task automatic t_id();
    run_op(nri_pkg::NRI_OP_ID, 5, 80);
    chk_seq('{MAKER, DEVICE, 8'h00_00, 8'h00_1A, 8'h00_00});
    run_op(nri_pkg::NRI_OP_STATUS, 1, 0);
    chk_seq('{8'h00_E0});
  endtask

  task automatic t_sig();
    run_op(nri_pkg::NRI_OP_ONFI, 4, 0);
    chk_seq('{8'h00_4F, 8'h00_4E, 8'h00_46, 8'h00_49});
    run_op(nri_pkg::NRI_OP_PARAM, 6, 10);
    chk_seq('{8'h00_4F, 8'h00_4E, 8'h00_46, 8'h00_49, 8'h00_02, 8'h00_00});
  endtask

  task automatic t_alt();
    run_op(nri_pkg::NRI_OP_ALT, 8, 40);
    chk_seq('{8'h00_FF, 8'h00_FF, 8'h00_FF, 8'h00_FF, 8'h00_FF, 8'h00_FF, 8'h00_FF, 8'h00_FF});
    chk_byte(8'(bad), 8'h00_00);
    // id read straight after an id-like mode: host must lead with the dummy command
    run_op(nri_pkg::NRI_OP_ID, 5, 0);
    chk_seq('{MAKER, DEVICE, 8'h00_00, 8'h00_1A, 8'h00_00});
  endtask

  // main sequence, then a second reset with write protect asserted
  initial begin
    repeat (16) @(negedge i_sys_clk);
    i_rst = 0;
    t_refused();
    t_reset(1'b1, 8'h00_E0);
    t_id();
    t_sig();
    t_alt();
    i_rst = 1;
    repeat (16) @(negedge i_sys_clk);
    i_rst = 0;
    t_refused();
    t_reset(1'b0, 8'h00_60);
    report_and_stop();
  end
endmodule
